// ---- logic/rate_timer_params.svh ----
// Constants for the rate generator timer: offsets, fields, reset values, divider counts
`ifndef RATE_TIMER_PARAMS_SVH
`define RATE_TIMER_PARAMS_SVH

// Register addresses on the plain register port
`define RT_ADDR_COUNT      8'h40   // Counter data register, byte wide
`define RT_ADDR_CONTROL    8'h43   // Control word register
`define RT_ADDR_STATUS     8'h44   // Sticky event status, write one to clear
`define RT_ADDR_MASK       8'h45   // Event mask for the level interrupt

// Control word fields
`define RT_CW_SEL_HI       7       // Counter select, ignored (only one counter)
`define RT_CW_SEL_LO       6
`define RT_CW_RW_HI        5       // Access field
`define RT_CW_RW_LO        4
`define RT_CW_RW_LATCH     2'h0
`define RT_CW_RW_LSB       2'h1
`define RT_CW_RW_MSB       2'h2
`define RT_CW_RW_WORD      2'h3
`define RT_CW_MODE_FIXED   3'h2    // Rate generator mode, hardwired

// Status and mask bits
`define RT_EV_TERMINAL     0       // Count reached one
`define RT_EV_LOADED       1       // Initial count loaded into counter
`define RT_EV_W            2

// Reset values
`define RT_RST_COUNT       16'h0000
`define RT_RST_MASK        2'h0
`define RT_RST_BYTE        8'h00

// Count values around the end of a period
`define RT_TERM_COUNT      16'h0001 // Count at which the request stands
`define RT_PRE_TERM        16'h0002 // Count whose tick raises the request

// Divider: short and long steps, last inner and outer sequence positions
`define RT_DIV_SHORT       27
`define RT_DIV_LONG        28
`define RT_INNER_LAST      2
`define RT_OUTER_LAST      34
`define RT_EXTRA_INNER     2       // Inner position of the last outer step that is short

`endif

// ---- logic/rate_timer_pkg.sv ----
// Types shared by the rate generator timer modules
package rate_timer_pkg;

   // Byte access state, Gray coded along latch, low, high, word
   typedef enum logic [1:0] {
      ACC_LATCH = 2'h0,
      ACC_LSB   = 2'h1,
      ACC_MSB   = 2'h3,
      ACC_WORD  = 2'h2
   } access_t;

   // One register port request
   typedef struct packed {
      logic [7:0] addr;    // Register address
      logic [7:0] wdata;   // Write data
      logic       write;   // One cycle write strobe
      logic       read;    // One cycle read strobe
   } reg_req_t;

   // Divider state
   typedef struct packed {
      logic [4:0] cnt;     // Clocks in the current step
      logic [1:0] inner;   // Inner sequence position
      logic [5:0] outer;   // Outer sequence position
      logic       tick;    // One clock tick pulse
   } div_state_t;

   // Output latch state
   typedef struct packed {
      logic        held;   // Frozen by a latch command
      logic [15:0] value;  // Latch contents
   } latch_state_t;

endpackage

// ---- logic/tick_divider.sv ----
// Free running divider producing the count tick from a fixed sequence of short and long steps
`timescale 1ns/100ps
`include "rate_timer_params.svh"

module tick_divider #(
   parameter int SHORT_DIV = `RT_DIV_SHORT,
   parameter int LONG_DIV  = `RT_DIV_LONG
) (
   input  wire logic clk,
   input  wire logic reset_n,
   output logic      tick
);

   // Refuse step lengths that the five bit counter cannot hold
   if (SHORT_DIV < 2 || LONG_DIV > 32 || LONG_DIV != SHORT_DIV + 1) begin
      $error("tick_divider: unsupported step lengths");
   end

   localparam int SHORT_GAP = SHORT_DIV; // Clocks from a short step start to its tick

   rate_timer_pkg::div_state_t s_r;   // Registered state
   rate_timer_pkg::div_state_t s_nxt; // Next state
   logic [4:0]                 stepLast; // Last count of the current step

   // Pick the step length from the sequence position; runs with no enable
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (s_r.inner == 2'h0 ||
          (s_r.outer == 6'(`RT_OUTER_LAST) && s_r.inner == 2'(`RT_EXTRA_INNER))) begin
         stepLast = 5'(SHORT_DIV - 1);
      end else begin
         stepLast = 5'(LONG_DIV - 1);
      end
      if (s_r.cnt == stepLast) begin
         s_nxt.cnt = 5'h00;
         s_nxt.tick = 1'b1;
         if (s_r.inner == 2'(`RT_INNER_LAST)) begin
            s_nxt.inner = 2'h0;
            s_nxt.outer = (s_r.outer == 6'(`RT_OUTER_LAST)) ? 6'h00 : s_r.outer + 6'h01;
         end else begin
            s_nxt.inner = s_r.inner + 2'h1;
         end
      end else begin
         s_nxt.cnt = s_r.cnt + 5'h01;
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;

   // Gap between ticks, checked against the step lengths
   logic [5:0] gap_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_r <= 6'h00;
      end else begin
         gap_r <= s_r.tick ? 6'h01 : gap_r + 6'h01;
      end
   end

   AST_TICK_GAP: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.tick && gap_r != 6'h00 && s_r.outer != 6'h00
      |-> gap_r == 6'(SHORT_DIV) || gap_r == 6'(LONG_DIV))
      else $error("tick spacing not a short or long step");
   AST_SEQ_WRAP: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.cnt == stepLast && s_r.inner == 2'(`RT_INNER_LAST)
      && s_r.outer == 6'(`RT_OUTER_LAST) |=> s_r.outer == 6'h00 && s_r.inner == 2'h0)
      else $error("divider sequence did not wrap");
   AST_SHORT_STEP: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.inner == 2'h0 && s_r.cnt == 5'h00 |-> ##SHORT_GAP s_r.tick)
      else $error("first inner step not short");
   COV_DIV_WRAP: cover property (@(posedge clk) disable iff (!reset_n)
      s_r.tick && s_r.outer == 6'h00 && s_r.inner == 2'h0);

endmodule

// ---- logic/count_latch.sv ----
// Output latch: follows the count, or holds it from a latch command until unlatch, raised by a high byte read or a byte access control word
`timescale 1ns/100ps

module count_latch #(
   parameter int COUNT_W = 16
) (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic [COUNT_W-1:0] liveCount,
   input  wire logic               latchCmd,
   input  wire logic               unlatch,
   output logic [COUNT_W-1:0]      latchValue,
   output logic                    held
);

   // Only a two byte count is served
   if (COUNT_W != 16) begin
      $error("count_latch: only a 16 bit count is supported");
   end

   rate_timer_pkg::latch_state_t s_r;   // Registered state
   rate_timer_pkg::latch_state_t s_nxt; // Next state

   // A latch command freezes the value; unlatch (high byte read or byte access control word) releases it
   always_comb begin
      s_nxt = s_r;
      if (latchCmd && !s_r.held) begin
         s_nxt.held = 1'b1;
         s_nxt.value = liveCount;
      end else if (unlatch) begin
         s_nxt.held = 1'b0;
         s_nxt.value = liveCount;
      end else if (!s_r.held) begin
         s_nxt.value = liveCount;
      end
   end

   // State register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign latchValue = s_r.value;
   assign held = s_r.held;

   AST_HOLD_STABLE: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.held && !unlatch |=> $stable(s_r.value))
      else $error("latched count changed while held");
   COV_LATCH_RELEASE: cover property (@(posedge clk) disable iff (!reset_n)
      s_r.held ##[1:20] unlatch);

endmodule

// ---- logic/rate_generator_timer.sv ----
// Single counter timer fixed in rate generator mode, with byte access and event interrupt
`timescale 1ns/100ps
`include "rate_timer_params.svh"

module rate_generator_timer #(
   parameter int COUNT_W = 16
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire rate_timer_pkg::reg_req_t busReq,
   output logic [7:0]                    busRdata,
   output logic                          timerIrq,
   output logic                          intReq
);

   // The byte access paths assume exactly two bytes of count
   if (COUNT_W != 16) begin
      $error("rate_generator_timer: only a 16 bit count is supported");
   end

   // Data paths in short:
   // the divider runs free and hands out a tick;
   // a written count loads, then steps once a tick;
   // the output latch trails the count by a clock,
   // or freezes it for one low and high byte pair;
   // reads are registered and stand for one cycle;
   // events set sticky bits, masked onto intReq.
   // Limitation: an unlatched word read can tear
   // when a borrow falls between the two byte reads.

   // Whole block state
   typedef struct packed {
      rate_timer_pkg::access_t access; // Current byte access state
      logic                    ctrlSeen;  // A control word has been written
      logic                    writeHigh; // Next word write is the high byte
      logic                    readHigh;  // Next word read is the high byte
      logic [COUNT_W-1:0]      initCount; // Initial count as written
      logic                    loadPending; // Load counter on next clock
      logic                    enabled;   // Counter running
      logic [COUNT_W-1:0]      count;     // Running count
      logic                    irqPulse;  // Request to interrupt control
      logic [`RT_EV_W-1:0]     status;    // Sticky events
      logic [`RT_EV_W-1:0]     mask;      // Event enables
      logic                    intReq;    // Level interrupt
      logic [7:0]              rdata;     // Read data, one cycle after strobe
   } timer_state_t;

   timer_state_t       s_r;        // Registered state
   timer_state_t       s_nxt;      // Next state
   logic               tick;       // Divider tick
   logic [COUNT_W-1:0] latchValue; // Output latch contents
   logic               latchHeld;  // Output latch frozen
   logic               latchCmd;   // Latch command this cycle
   logic               latchRel;   // High byte of a held value read, or a control word with a byte access
   logic               loadDone;   // Count load event
   logic               termEvent;  // Count reached one

   // Map the access field of a control word onto the access state
   function automatic rate_timer_pkg::access_t decodeAccess(input logic [1:0] rw);
      case (rw)
         `RT_CW_RW_LSB:  decodeAccess = rate_timer_pkg::ACC_LSB;
         `RT_CW_RW_MSB:  decodeAccess = rate_timer_pkg::ACC_MSB;
         `RT_CW_RW_WORD: decodeAccess = rate_timer_pkg::ACC_WORD;
         default:        decodeAccess = rate_timer_pkg::ACC_LATCH;
      endcase
   endfunction

   // Access field as it reads back in the control register
   function automatic logic [1:0] encodeAccess(input rate_timer_pkg::access_t acc);
      case (acc)
         rate_timer_pkg::ACC_LSB:  encodeAccess = `RT_CW_RW_LSB;
         rate_timer_pkg::ACC_MSB:  encodeAccess = `RT_CW_RW_MSB;
         rate_timer_pkg::ACC_WORD: encodeAccess = `RT_CW_RW_WORD;
         default:                  encodeAccess = `RT_CW_RW_LATCH;
      endcase
   endfunction

   // Write strobe aimed at one register address
   function automatic logic writesTo(input rate_timer_pkg::reg_req_t req,
                                     input logic [7:0]               addr);
      writesTo = req.write && req.addr == addr;
   endfunction

   // Divider: free running from reset
   tick_divider #(
      .SHORT_DIV (`RT_DIV_SHORT),
      .LONG_DIV  (`RT_DIV_LONG)
   ) divider (
      .clk     (clk),
      .reset_n (reset_n),
      .tick    (tick)
   );

   // Output latch, fed with the running count
   count_latch #(
      .COUNT_W (COUNT_W)
   ) outLatch (
      .clk        (clk),
      .reset_n    (reset_n),
      .liveCount  (s_r.count),
      .latchCmd   (latchCmd),
      .unlatch    (latchRel),
      .latchValue (latchValue),
      .held       (latchHeld)
   );

   // Next state: register port, count load, decrement, events
   always_comb begin
      s_nxt = s_r;
      latchCmd = 1'b0;
      latchRel = 1'b0;
      loadDone = 1'b0;
      termEvent = 1'b0;
      s_nxt.irqPulse = 1'b0;

      // Control word: counter select and mode are hardwired, only access is taken
      if (writesTo(busReq, `RT_ADDR_CONTROL)) begin
         s_nxt.access = decodeAccess(busReq.wdata[`RT_CW_RW_HI:`RT_CW_RW_LO]);
         s_nxt.ctrlSeen = 1'b1;
         s_nxt.writeHigh = 1'b0;
         s_nxt.readHigh = 1'b0;
         if (busReq.wdata[`RT_CW_RW_HI:`RT_CW_RW_LO] == `RT_CW_RW_LATCH) begin
            latchCmd = 1'b1;
         end else begin
            // Byte states read the live count, so drop any freeze
            latchRel = 1'b1;
         end
      end

      // Initial count write in the selected byte order
      if (writesTo(busReq, `RT_ADDR_COUNT)) begin
         case (s_r.access)
            // Single byte states clear the other byte
            rate_timer_pkg::ACC_LSB: begin
               s_nxt.initCount = {8'h00, busReq.wdata};
               s_nxt.loadPending = s_r.ctrlSeen;
            end
            rate_timer_pkg::ACC_MSB: begin
               s_nxt.initCount = {busReq.wdata, 8'h00};
               s_nxt.loadPending = s_r.ctrlSeen;
            end
            rate_timer_pkg::ACC_WORD: begin
               if (s_r.writeHigh) begin
                  s_nxt.initCount[15:8] = busReq.wdata;
                  s_nxt.writeHigh = 1'b0;
                  s_nxt.loadPending = s_r.ctrlSeen;
               end else begin
                  s_nxt.initCount[7:0] = busReq.wdata;
                  s_nxt.writeHigh = 1'b1;
               end
            end
            default: begin
               // Writes in the latch state carry no count and are dropped
            end
         endcase
      end

      // Read data; only the counter has byte ordering side effects
      s_nxt.rdata = `RT_RST_BYTE;
      if (busReq.read) begin
         case (busReq.addr)
            `RT_ADDR_COUNT: begin
               case (s_r.access)
                  rate_timer_pkg::ACC_LSB: s_nxt.rdata = latchValue[7:0];
                  rate_timer_pkg::ACC_MSB: s_nxt.rdata = latchValue[15:8];
                  default: begin
                     // Latch and word states: low byte first, then high
                     s_nxt.rdata = s_r.readHigh ? latchValue[15:8] : latchValue[7:0];
                     s_nxt.readHigh = !s_r.readHigh;
                     latchRel = s_r.readHigh && latchHeld;
                  end
               endcase
            end
            `RT_ADDR_CONTROL: begin
               s_nxt.rdata = {2'h0, encodeAccess(s_r.access), `RT_CW_MODE_FIXED, 1'b0};
            end
            `RT_ADDR_STATUS: s_nxt.rdata = 8'(s_r.status);
            `RT_ADDR_MASK:   s_nxt.rdata = 8'(s_r.mask);
            default:         s_nxt.rdata = `RT_RST_BYTE;
         endcase
      end

      // Count: load wins over a tick, so a fresh count always starts whole
      if (s_r.loadPending) begin
         s_nxt.count = s_r.initCount;
         s_nxt.enabled = 1'b1;
         s_nxt.loadPending = 1'b0;
         loadDone = 1'b1;
      end else if (s_r.enabled && tick) begin
         // A count of one reloads on every tick and never raises a request
         if (s_r.count == `RT_TERM_COUNT) begin
            s_nxt.count = s_r.initCount;
         end else begin
            s_nxt.count = s_r.count - 16'h0001;
            // Request stands in the clock in which the count reads one
            if (s_r.count == `RT_PRE_TERM) begin
               s_nxt.irqPulse = 1'b1;
               termEvent = 1'b1;
            end
         end
      end

      // Sticky events: a set in the same cycle as a clear wins
      if (writesTo(busReq, `RT_ADDR_STATUS)) begin
         s_nxt.status = s_r.status & ~busReq.wdata[`RT_EV_W-1:0];
      end
      if (writesTo(busReq, `RT_ADDR_MASK)) begin
         s_nxt.mask = busReq.wdata[`RT_EV_W-1:0];
      end
      s_nxt.status[`RT_EV_TERMINAL] = s_nxt.status[`RT_EV_TERMINAL] | termEvent;
      s_nxt.status[`RT_EV_LOADED] = s_nxt.status[`RT_EV_LOADED] | loadDone;
      s_nxt.intReq = |(s_nxt.status & s_nxt.mask);
   end

   // State register; counter starts disabled
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.access <= rate_timer_pkg::ACC_WORD;
         s_r.count <= `RT_RST_COUNT;
         s_r.mask <= `RT_RST_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busRdata = s_r.rdata;
   assign timerIrq = s_r.irqPulse;
   assign intReq = s_r.intReq;

   // Checks beside the logic

   AST_CTRL_ACCESS: assert property (@(posedge clk) disable iff (!reset_n)
      busReq.write && busReq.addr == `RT_ADDR_CONTROL
      |=> s_r.access == decodeAccess($past(busReq.wdata[`RT_CW_RW_HI:`RT_CW_RW_LO])))
      else $error("access state does not follow control word");
   AST_LATCH_LOW_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
      latchHeld && s_r.access == rate_timer_pkg::ACC_LATCH && !s_r.readHigh
      && busReq.read && busReq.addr == `RT_ADDR_COUNT |=> busRdata == $past(latchValue[7:0]))
      else $error("latched read did not return low byte first");
   AST_MSB_READ: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.access == rate_timer_pkg::ACC_MSB && busReq.read && busReq.addr == `RT_ADDR_COUNT
      |=> busRdata == $past(latchValue[15:8]) && !latchHeld)
      else $error("high byte read wrong");
   AST_STAYS_OFF: assert property (@(posedge clk) disable iff (!reset_n)
      !s_r.enabled && !s_r.loadPending |=> !s_r.enabled && !timerIrq)
      else $error("counter ran before a count was written");
   AST_LOAD_NEXT: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.loadPending |=> s_r.enabled && s_r.count == $past(s_r.initCount))
      else $error("count not loaded on next clock");
   AST_IRQ_ONE_CLOCK: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(timerIrq) |-> s_r.count == 16'h0001 ##1 !timerIrq)
      else $error("request not a single clock at count one");
   AST_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.enabled && tick && !s_r.loadPending && s_r.count == 16'h0001
      |=> s_r.count == $past(s_r.initCount))
      else $error("counter did not reload");
   AST_DECREMENT: assert property (@(posedge clk) disable iff (!reset_n)
      s_r.enabled && !s_r.loadPending && s_r.count != 16'h0001
      |=> s_r.count == ($past(tick) ? $past(s_r.count) - 16'h0001 : $past(s_r.count)))
      else $error("counter step not one per tick");
   AST_INT_LEVEL: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(timerIrq) && s_r.mask[`RT_EV_TERMINAL] |-> intReq)
      else $error("unmasked event did not raise interrupt");

   // Register port and byte path checks
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
      !busReq.read |=> busRdata == `RT_RST_BYTE)
      else $error("read data not idle after a cycle with no read");
   AST_MODE_FIXED: assert property (@(posedge clk) disable iff (!reset_n)
      busReq.read && busReq.addr == `RT_ADDR_CONTROL |=> busRdata[3:1] == `RT_CW_MODE_FIXED)
      else $error("mode field of control word not fixed");
   AST_UNLATCH: assert property (@(posedge clk) disable iff (!reset_n)
      writesTo(busReq, `RT_ADDR_CONTROL)
      && busReq.wdata[`RT_CW_RW_HI:`RT_CW_RW_LO] != `RT_CW_RW_LATCH |=> !latchHeld)
      else $error("byte access state left the count frozen");
   AST_LATCH_TAKE: assert property (@(posedge clk) disable iff (!reset_n)
      latchCmd && !latchHeld |=> latchHeld && latchValue == $past(s_r.count))
      else $error("latch command did not freeze the count");
   AST_HIGH_FREES: assert property (@(posedge clk) disable iff (!reset_n)
      latchHeld && s_r.readHigh && busReq.read && busReq.addr == `RT_ADDR_COUNT
      |=> !latchHeld)
      else $error("high byte read did not release the latch");
   AST_LSB_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
      writesTo(busReq, `RT_ADDR_COUNT) && s_r.access == rate_timer_pkg::ACC_LSB
      |=> s_r.initCount == {8'h00, $past(busReq.wdata)})
      else $error("low byte write did not clear the high byte");
   AST_NO_EARLY_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
      writesTo(busReq, `RT_ADDR_COUNT) && !s_r.ctrlSeen |=> !s_r.loadPending)
      else $error("count write before a control word armed a load");
   AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
      termEvent |=> s_r.status[`RT_EV_TERMINAL])
      else $error("terminal event lost to a clear");

   COV_IRQ: cover property (@(posedge clk) disable iff (!reset_n) timerIrq);
   COV_WORD_LOAD: cover property (@(posedge clk) disable iff (!reset_n)
      s_r.access == rate_timer_pkg::ACC_WORD && s_r.loadPending);
   COV_LATCH_CMD: cover property (@(posedge clk) disable iff (!reset_n) latchCmd);

endmodule

// ---- tb/irq_sink.sv ----
// Interrupt controller side model: counts request pulses and measures their spacing
`timescale 1ns/100ps

module irq_sink (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic timerIrq,
   output int        pulseCnt,
   output int        lastGap,
   output logic      wideSeen
);
   logic irqPrev_r;   // Request seen on the previous clock
   int   since_r;     // Clocks since the last rising request

   // Edge detect only: a level held high would be counted once, so width is flagged apart
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irqPrev_r <= 1'b0;
         since_r   <= 0;
         pulseCnt  <= 0;
         lastGap   <= 0;
         wideSeen  <= 1'b0;
      end else begin
         irqPrev_r <= timerIrq;
         if (timerIrq && !irqPrev_r) begin
            // New request: record spacing from the previous one
            pulseCnt <= pulseCnt + 1;
            lastGap  <= since_r;
            since_r  <= 1;
         end else begin
            since_r <= since_r + 1;
         end
         if (timerIrq && irqPrev_r) begin
            // Request wider than one clock
            wideSeen <= 1'b1;
         end
      end
   end
endmodule

// ---- tb/rate_generator_timer_tb.sv ----
// Self-checking bench for the rate generator timer over its plain register port
`timescale 1ns/100ps

module rate_generator_timer_tb;
   logic                     clk;         // 250 MHz bench clock
   logic                     reset_n;     // Active low reset
   rate_timer_pkg::reg_req_t busReq;      // Register port request
   logic [7:0]               busRdata;    // Read data
   logic                     timerIrq;    // Request pulse
   logic                     intReq;      // Level interrupt
   int                       pulseCnt;    // Pulses seen by the sink
   int                       lastGap;     // Clocks between last two pulses
   logic                     wideSeen;    // Pulse wider than one clock
   int                       n_mismatch;  // Failed comparisons
   int                       n_compared;  // Comparisons made
   logic [7:0]               d;           // Read scratch
   logic [15:0]              v1;          // Count samples
   logic [15:0]              v2;

   rate_generator_timer i_rate_generator_timer (
      .clk      (clk),
      .reset_n  (reset_n),
      .busReq   (busReq),
      .busRdata (busRdata),
      .timerIrq (timerIrq),
      .intReq   (intReq)
   );

   irq_sink i_irq_sink (
      .clk      (clk),
      .reset_n  (reset_n),
      .timerIrq (timerIrq),
      .pulseCnt (pulseCnt),
      .lastGap  (lastGap),
      .wideSeen (wideSeen)
   );

   // Clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Verdict and end of run, shared by the tests and the watchdog
   task automatic close_out;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Byte comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t byte got %h expected %h", $time, got, exp);
      end
   endtask

   // Condition comparison
   task automatic chkb(input logic c);
      n_compared++;
      if (c !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH %0t condition false", $time);
      end
   endtask

   // One cycle write strobe, launched after an edge
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      @(posedge clk);
      busReq.addr  <= a;
      busReq.wdata <= wd;
      busReq.write <= 1'b1;
      @(posedge clk);
      busReq.write <= 1'b0;
   endtask

   // One cycle read strobe; data stand only in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] rdv);
      @(posedge clk);
      busReq.addr <= a;
      busReq.read <= 1'b1;
      @(posedge clk);
      busReq.read <= 1'b0;
      @(negedge clk);
      rdv = busRdata;
   endtask

   // Low then high byte of the count
   task automatic rd16(output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(8'h40, lo);
      rd(8'h40, hi);
      v = {hi, lo};
   endtask

   // Bounded wait for the next request pulse
   task automatic wait_irq;
      int n0;
      int k;
      n0 = pulseCnt;
      k = 0;
      while (pulseCnt == n0 && k < 4000) begin
         @(posedge clk);
         k++;
      end
      if (pulseCnt == n0) begin
         n_mismatch++;
         $display("MISMATCH %0t no request pulse", $time);
      end
   endtask

   // Watchdog: the tests need some 10000 clocks
   initial begin
      #160000;
      n_mismatch++;
      $display("MISMATCH %0t watchdog expired", $time);
      close_out();
   end

   // Test sequence
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      reset_n    = 1'b0;
      busReq     = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      // Unmapped place reads zero and ignores writes
      wr(8'h41, 8'hff);
      rd(8'h41, d);
      chk(d, 8'h00);
      // Count written before any control word must not start the counter
      wr(8'h40, 8'h03);
      wr(8'h40, 8'h00);
      repeat (300) @(posedge clk);
      chkb(pulseCnt == 0);
      rd(8'h44, d);
      chk(d, 8'h00);
      // Select bits and mode are fixed whatever is written
      wr(8'h43, 8'hdf);
      rd(8'h43, d);
      chk(d, 8'h14);
      // Every access state reads back; a latch taken here is dropped by the next control word
      for (int rw = 0; rw < 4; rw++) begin
         wr(8'h43, {2'b00, rw[1:0], 4'h4});
         rd(8'h43, d);
         chk(d, {2'b00, rw[1:0], 4'h4});
      end
      rd16(v1);
      // Period of three ticks, terminal event unmasked
      wr(8'h45, 8'h01);
      wr(8'h43, 8'h34);
      wr(8'h40, 8'h03);
      wr(8'h40, 8'h00);
      repeat (4) @(posedge clk);
      rd(8'h44, d);
      chk(d & 8'h02, 8'h02);
      wait_irq();
      wait_irq();
      chkb(lastGap == 82 || lastGap == 83);
      repeat (3) @(posedge clk);
      chkb(intReq === 1'b1);
      wr(8'h44, 8'h01);
      repeat (2) @(posedge clk);
      chkb(intReq === 1'b0);
      wr(8'h45, 8'h00);
      wait_irq();
      repeat (3) @(posedge clk);
      chkb(intReq === 1'b0);
      chkb(wideSeen === 1'b0);
      rd(8'h44, d);
      chk(d & 8'h01, 8'h01);
      // Word state: count runs between reads
      wr(8'h43, 8'h34);
      wr(8'h40, 8'h80);
      wr(8'h40, 8'h10);
      repeat (10) @(posedge clk);
      rd16(v1);
      repeat (300) @(posedge clk);
      rd16(v2);
      chkb(v1 <= 16'h1080 && v1 - v2 >= 16'h0009 && v1 - v2 <= 16'h000d);
      // Latch: value frozen between low and high read, released after high
      wr(8'h43, 8'h04);
      rd(8'h40, d);
      v1[7:0] = d;
      repeat (300) @(posedge clk);
      rd(8'h40, d);
      v1[15:8] = d;
      wr(8'h43, 8'h04);
      rd16(v2);
      chkb(v1 - v2 >= 16'h0009 && v1 - v2 <= 16'h000d);
      // Low byte only, high byte cleared
      wr(8'h43, 8'h14);
      wr(8'h40, 8'h50);
      repeat (10) @(posedge clk);
      rd(8'h40, d);
      chkb(d == 8'h50 || d == 8'h4f);
      // High byte only, low byte cleared
      wr(8'h43, 8'h24);
      wr(8'h40, 8'h02);
      repeat (10) @(posedge clk);
      rd(8'h40, d);
      chkb(d == 8'h02 || d == 8'h01);
      // 105 ticks span the whole divider sequence: 35 outer positions of 83 clocks less one clock
      wr(8'h43, 8'h34);
      wr(8'h40, 8'h69);
      wr(8'h40, 8'h00);
      wait_irq();
      wait_irq();
      wait_irq();
      chkb(lastGap == 2904);
      close_out();
   end
endmodule
